// file: pkg/spf_pkg.sv
// Constants and types shared by the scanner packet framer.
package spf_pkg;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS = 8;
   localparam int unsigned TIME_UNIT_NS = 1000;
   localparam int unsigned US_CYCLES = (TIME_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ------------------------------------------------------------
   // Register byte offsets and block address prefixes
   // ------------------------------------------------------------
   localparam logic [11:0] REG_CTRL = 12'h000;
   localparam logic [11:0] REG_KEY = 12'h004;
   localparam logic [11:0] REG_STATUS = 12'h008;
   localparam logic [11:0] REG_END = 12'h00c;
   localparam logic [11:0] REG_HEALTH = 12'h010;
   localparam logic [11:0] REG_TIME_LO = 12'h014;
   localparam logic [11:0] REG_TIME_HI = 12'h018;
   localparam logic [11:0] REG_SEQ = 12'h01c;
   localparam logic [11:0] REG_STATE = 12'h020;
   localparam logic [11:0] REG_TEMP = 12'h024;
   localparam logic [6:0] REG_TOFF_BLK = 7'h02;
   localparam logic [3:0] REG_PRES_BLK = 4'h1;

   // ------------------------------------------------------------
   // Reset values and packet constants
   // ------------------------------------------------------------
   localparam logic [15:0] LEN_FULL = 16'h0093;
   localparam logic [15:0] LEN_GROUP = 16'h001b;
   localparam logic [15:0] STATUS_RST = 16'h0000;
   localparam logic [15:0] END_RST = 16'hdead;
   localparam logic [2:0] HDR_LAST = 3'h6;
   localparam logic [2:0] TAIL_LAST = 3'h3;
   localparam logic [4:0] GRP_LAST = 5'h10;
   localparam logic [2:0] GROUP_LAST = 3'h7;

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int unsigned CTRL_START = 0;
   localparam int unsigned CTRL_GROUP_MODE = 1;
   localparam int unsigned CTRL_HEATER = 2;
   localparam int unsigned CTRL_PURGE = 3;
   localparam int unsigned CTRL_LAYOUT_B = 4;
   localparam int unsigned H_POS_LO = 0;
   localparam int unsigned H_STUCK = 2;
   localparam int unsigned H_OVERTEMP = 3;
   localparam int unsigned H_COMP_LO = 4;
   localparam int unsigned H_THERMO = 8;
   localparam int unsigned H_MOD_ERR = 9;
   localparam int unsigned H_BAKE_LO = 16;

   // ------------------------------------------------------------
   // Sequencer states
   // ------------------------------------------------------------
   typedef enum logic [1:0] {SPF_IDLE, SPF_HDR, SPF_GRP, SPF_TAIL} spf_state_t;

endpackage : spf_pkg

// file: hdl/spf_framer.sv
// Scanner UDP payload framer with APB register file and byte stream output.
//
// The implementer's own choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
// Function
// - Per-group packets use key field equal to base key plus group index.
// - Full packet word 1 carries length 147.
// - Words 2 to 4 carry 48-bit microsecond time, high pair first.
// - Word 5 carries configured status, zero by default.
// - Word 6 carries 16-bit sequence count, advancing per packet and wrapping.
// - Each full-packet group opens with its time offset word.
// - Eight pressures follow per group, ascending channel, upper pair first.
// - Words 143 and 144 carry temperature float, upper pair first.
// - Word 145 carries health word, word 146 the end marker, default 0xdead.
// - First health layout has bit 15 zero and reserved bits 14 to 10.
// - Bit 9 flags sensor module communication failure.
// - Bit 8 flags heater setpoint reached, zero without heater.
// - Bits 7 to 4 flag modules D, C, B, A out of range.
// - Bit 3 flags scanner over maximum operating temperature.
// - Bit 2 flags stuck purge motor, zero without motorized purge.
// - Bits 1 to 0 give purge position code.
// - Purge position is 00 without motorized purge.
// - Second health layout has bit 15 set and bits 14 to 2 zero.
// - Second layout bits 1 to 0 give bake progress, zero without heater.
// - Per-group packets declare length 27.
module spf_framer
   import spf_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic tx_ready,
   output logic [7:0] tx_data,
   output logic tx_valid,
   output logic tx_sop,
   output logic tx_eop,
   output logic busy
);

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   logic [4:0] ctrl_q;
   logic [15:0] key_q;
   logic [15:0] status_q;
   logic [15:0] end_q;
   logic [17:0] health_in_q;
   logic [31:0] temp_q;
   logic [31:0] time_lo_stage_q;
   logic [15:0] toff_q [8];
   logic [31:0] pres_mem [64];
   logic [31:0] prdata_q;
   logic pready_q;
   logic pslverr_q;
   logic start_q;
   logic [47:0] time_q;
   logic [6:0] us_div_q;
   logic time_load;
   logic [47:0] time_load_val;
   spf_state_t state_q;
   logic [2:0] wcnt_q;
   logic [4:0] sub_q;
   logic [2:0] grp_q;
   logic byte_q;
   logic [15:0] seq_q;
   logic [47:0] ts_q;
   logic [7:0] tx_data_q;
   logic tx_valid_q;
   logic tx_sop_q;
   logic tx_eop_q;
   logic busy_q;
   logic wr_commit;
   logic rd_access;
   logic hit;
   logic [31:0] rdata;
   logic load;
   logic word_done;
   logic group_mode;
   logic [4:0] sub_m1;
   logic [31:0] pres_sel;
   logic [15:0] health_word;
   logic [15:0] cur_word;

   assign rd_access = psel && penable && !pready_q;
   assign wr_commit = psel && penable && pready_q && pwrite;
   assign group_mode = ctrl_q[CTRL_GROUP_MODE];
   assign load = !tx_valid_q || tx_ready;
   assign word_done = load && byte_q && (state_q != SPF_IDLE);
   assign time_load = wr_commit && hit && (paddr == REG_TIME_HI);
   assign time_load_val = {pwdata[15:0], time_lo_stage_q};

   // ------------------------------------------------------------
   // Address decode and read mux
   // ------------------------------------------------------------
   always_comb begin
      hit = 1'b1;
      rdata = 32'h0000_0000;
      if (paddr[1:0] != 2'b00) begin
         hit = 1'b0;
      end else if (paddr[11:8] == REG_PRES_BLK) begin
         rdata = pres_mem[paddr[7:2]];
      end else if (paddr[11:5] == REG_TOFF_BLK) begin
         rdata = {16'h0000, toff_q[paddr[4:2]]};
      end else begin
         case (paddr)
            REG_CTRL: rdata = {27'h0000000, ctrl_q};
            REG_KEY: rdata = {16'h0000, key_q};
            REG_STATUS: rdata = {16'h0000, status_q};
            REG_END: rdata = {16'h0000, end_q};
            REG_HEALTH: rdata = {14'h0000, health_in_q};
            REG_TIME_LO: rdata = time_q[31:0];
            REG_TIME_HI: rdata = {16'h0000, time_q[47:32]};
            REG_SEQ: rdata = {16'h0000, seq_q};
            REG_STATE: rdata = {24'h000000, busy_q, grp_q, 4'h0};
            REG_TEMP: rdata = temp_q;
            default: hit = 1'b0;
         endcase
      end
   end

   // ------------------------------------------------------------
   // APB handshake
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end else begin
         pready_q <= rd_access;
         if (rd_access) begin
            prdata_q <= pwrite ? 32'h0000_0000 : rdata;
            pslverr_q <= !hit;
         end
      end
   end

   // ------------------------------------------------------------
   // Configuration registers
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= 5'h00;
         key_q <= 16'h0000;
         status_q <= STATUS_RST;
         end_q <= END_RST;
         health_in_q <= 18'h00000;
         temp_q <= 32'h0000_0000;
         time_lo_stage_q <= 32'h0000_0000;
         start_q <= 1'b0;
         for (int i = 0; i < 8; i++) begin
            toff_q[i] <= 16'h0000;
         end
      end else begin
         start_q <= 1'b0;
         if (wr_commit && hit) begin
            if (paddr[11:5] == REG_TOFF_BLK) begin
               toff_q[paddr[4:2]] <= pwdata[15:0];
            end
            case (paddr)
               REG_CTRL: begin
                  ctrl_q <= {pwdata[4:1], 1'b0};
                  start_q <= pwdata[CTRL_START] && !busy_q;
               end
               REG_KEY: key_q <= pwdata[15:0];
               REG_STATUS: status_q <= pwdata[15:0];
               REG_END: end_q <= pwdata[15:0];
               REG_HEALTH: health_in_q <= pwdata[17:0];
               REG_TIME_LO: time_lo_stage_q <= pwdata;
               REG_TEMP: temp_q <= pwdata;
               default: ;
            endcase
         end
      end
   end

   // ------------------------------------------------------------
   // Pressure sample memory
   // ------------------------------------------------------------
   always_ff @(posedge pclk) begin
      if (wr_commit && (paddr[11:8] == REG_PRES_BLK) && (paddr[1:0] == 2'b00)) begin
         pres_mem[paddr[7:2]] <= pwdata;
      end
   end

   // ------------------------------------------------------------
   // Microsecond time base
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         us_div_q <= 7'h00;
         time_q <= 48'h0000_0000_0000;
      end else if (time_load) begin
         us_div_q <= 7'h00;
         time_q <= time_load_val;
      end else if (us_div_q == 7'(US_CYCLES - 1)) begin
         us_div_q <= 7'h00;
         time_q <= time_q + 48'h0000_0000_0001;
      end else begin
         us_div_q <= us_div_q + 7'h01;
      end
   end

   // ------------------------------------------------------------
   // Health word packing
   // ------------------------------------------------------------
   always_comb begin
      if (ctrl_q[CTRL_LAYOUT_B]) begin
         health_word = 16'h8000;
         if (ctrl_q[CTRL_HEATER]) begin
            health_word[1:0] = health_in_q[H_BAKE_LO +: 2];
         end
      end else begin
         health_word = 16'h0000;
         health_word[9] = health_in_q[H_MOD_ERR];
         health_word[8] = health_in_q[H_THERMO] && ctrl_q[CTRL_HEATER];
         health_word[7:4] = health_in_q[H_COMP_LO +: 4];
         health_word[3] = health_in_q[H_OVERTEMP];
         health_word[2] = health_in_q[H_STUCK] && ctrl_q[CTRL_PURGE];
         if (ctrl_q[CTRL_PURGE]) begin
            health_word[1:0] = health_in_q[H_POS_LO +: 2];
         end else begin
            health_word[1:0] = 2'b00;
         end
      end
   end

   // ------------------------------------------------------------
   // Payload word selection
   // ------------------------------------------------------------
   assign sub_m1 = sub_q - 5'h01;
   assign pres_sel = pres_mem[{sub_m1[3:1], grp_q}];

   always_comb begin
      cur_word = 16'h0000;
      case (state_q)
         SPF_HDR: begin
            case (wcnt_q)
               3'h0: cur_word = key_q + (group_mode ? {13'h0000, grp_q} : 16'h0000);
               3'h1: cur_word = group_mode ? LEN_GROUP : LEN_FULL;
               3'h2: cur_word = ts_q[47:32];
               3'h3: cur_word = ts_q[31:16];
               3'h4: cur_word = ts_q[15:0];
               3'h5: cur_word = status_q;
               default: cur_word = seq_q;
            endcase
         end
         SPF_GRP: begin
            if (sub_q == 5'h00) begin
               cur_word = toff_q[grp_q];
            end else begin
               cur_word = sub_q[0] ? pres_sel[31:16] : pres_sel[15:0];
            end
         end
         SPF_TAIL: begin
            case (wcnt_q)
               3'h0: cur_word = temp_q[31:16];
               3'h1: cur_word = temp_q[15:0];
               3'h2: cur_word = health_word;
               default: cur_word = end_q;
            endcase
         end
         default: cur_word = 16'h0000;
      endcase
   end

   // ------------------------------------------------------------
   // Packet sequencer
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= SPF_IDLE;
         wcnt_q <= 3'h0;
         sub_q <= 5'h00;
         grp_q <= 3'h0;
         byte_q <= 1'b0;
         seq_q <= 16'h0000;
         ts_q <= 48'h0000_0000_0000;
      end else begin
         if (load && state_q != SPF_IDLE) begin
            byte_q <= !byte_q;
         end
         case (state_q)
            SPF_IDLE: begin
               if (start_q) begin
                  state_q <= SPF_HDR;
                  wcnt_q <= 3'h0;
                  grp_q <= 3'h0;
                  byte_q <= 1'b0;
                  ts_q <= time_q;
               end
            end
            SPF_HDR: begin
               if (word_done) begin
                  if (wcnt_q == HDR_LAST) begin
                     state_q <= SPF_GRP;
                     sub_q <= group_mode ? 5'h01 : 5'h00;
                  end else begin
                     wcnt_q <= wcnt_q + 3'h1;
                  end
               end
            end
            SPF_GRP: begin
               if (word_done) begin
                  if (sub_q != GRP_LAST) begin
                     sub_q <= sub_q + 5'h01;
                  end else if (!group_mode && grp_q != GROUP_LAST) begin
                     grp_q <= grp_q + 3'h1;
                     sub_q <= 5'h00;
                  end else begin
                     state_q <= SPF_TAIL;
                     wcnt_q <= 3'h0;
                  end
               end
            end
            SPF_TAIL: begin
               if (word_done) begin
                  if (wcnt_q == TAIL_LAST) begin
                     seq_q <= seq_q + 16'h0001;
                     wcnt_q <= 3'h0;
                     if (group_mode && grp_q != GROUP_LAST) begin
                        grp_q <= grp_q + 3'h1;
                        state_q <= SPF_HDR;
                        ts_q <= time_q;
                     end else begin
                        state_q <= SPF_IDLE;
                     end
                  end else begin
                     wcnt_q <= wcnt_q + 3'h1;
                  end
               end
            end
            default: state_q <= SPF_IDLE;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Byte stream output
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_data_q <= 8'h00;
         tx_valid_q <= 1'b0;
         tx_sop_q <= 1'b0;
         tx_eop_q <= 1'b0;
         busy_q <= 1'b0;
      end else begin
         busy_q <= (state_q != SPF_IDLE) || start_q || tx_valid_q;
         if (load) begin
            tx_valid_q <= state_q != SPF_IDLE;
            tx_data_q <= byte_q ? cur_word[7:0] : cur_word[15:8];
            tx_sop_q <= (state_q == SPF_HDR) && (wcnt_q == 3'h0) && !byte_q;
            tx_eop_q <= (state_q == SPF_TAIL) && (wcnt_q == TAIL_LAST) && byte_q;
         end
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign tx_data = tx_data_q;
   assign tx_valid = tx_valid_q;
   assign tx_sop = tx_sop_q;
   assign tx_eop = tx_eop_q;
   assign busy = busy_q;

endmodule : spf_framer

// file: testbench/spf_checker.sv
// Port checker for the scanner packet framer.
`timescale 1ns/1ps
module spf_checker
   import spf_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic tx_ready,
   input wire logic [7:0] tx_data,
   input wire logic tx_valid,
   input wire logic tx_sop,
   input wire logic tx_eop,
   input wire logic busy
);
   // ---------------------------------------------
   // Byte position and layout tracking
   // ---------------------------------------------
   logic [8:0] cnt_q;
   logic grp_q;
   logic lay_q;
   logic take;
   logic wr_ctrl;
   assign take = tx_valid && tx_ready;
   assign wr_ctrl = psel && penable && pready && pwrite && paddr == REG_CTRL;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= 9'h000;
      end else if (take) begin
         cnt_q <= tx_eop ? 9'h000 : cnt_q + 9'h001;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         grp_q <= 1'b0;
      end else if (take && cnt_q == 9'h003) begin
         grp_q <= tx_data == 8'h1b;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lay_q <= 1'b0;
      end else if (wr_ctrl) begin
         lay_q <= pwdata[CTRL_LAYOUT_B];
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_ready_wait: assert property (psel && penable && !pready |=> pready)
      else $error("access phase not answered after one wait");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("ready held longer than one cycle");
   a_err_data: assert property (pready && pslverr |-> prdata == 32'h0)
      else $error("refused access returned data");
   a_tx_hold: assert property (
      tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_eop))
      else $error("byte changed while stalled");
   a_sop_first: assert property (tx_valid && tx_sop |-> cnt_q == 9'h000)
      else $error("start flag off the first byte");
   a_pkt_len: assert property (
      take && tx_eop |-> cnt_q == (grp_q ? 9'h035 : 9'h125))
      else $error("packet byte count wrong");
   a_len_field: assert property (
      take && cnt_q == 9'h003 |-> tx_data == 8'h93 || tx_data == 8'h1b)
      else $error("length field wrong");
   a_health_flag: assert property (
      take && cnt_q == (grp_q ? 9'h032 : 9'h122) |->
      tx_data[7] == lay_q && tx_data[6:2] == 5'h00 && (!lay_q || tx_data[1:0] == 2'h0))
      else $error("health word layout bits wrong");
   a_start_lat: assert property (
      wr_ctrl && pwdata[CTRL_START] && !busy |-> ##3 tx_valid && tx_sop)
      else $error("packet did not start on time");
   c_full: cover property (take && tx_eop && !grp_q);
   c_group: cover property (take && tx_eop && grp_q);
   c_err: cover property (pready && pslverr);
   c_stall: cover property (tx_valid && !tx_ready);
endmodule : spf_checker

bind spf_framer spf_checker spf_checker_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
   .pwdata, .prdata, .pready, .pslverr, .tx_ready, .tx_data, .tx_valid, .tx_sop, .tx_eop, .busy);

// file: testbench/spf_sink.sv
// Stream sink standing in for the network receiver.
`timescale 1ns/1ps
module spf_sink (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic stall,
   output logic tx_ready
);
   int seed = 97;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_ready <= 1'b0;
      end else begin
         tx_ready <= !stall || ($random(seed) & 3) != 0;
      end
   end
endmodule : spf_sink

// file: testbench/tb_top.sv
// Self-checking bench for the scanner packet framer.
`timescale 1ns/1ps
module tb_top;
   import spf_pkg::*;
   // ---------------------------------------------
   // Signals and stimulus
   // ---------------------------------------------
   logic pclk, presetn, psel, penable, pwrite, stall, err_q, hi_seen, grp;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd_q, c, hreg, temp;
   logic pready, pslverr, tx_ready, tx_valid, tx_sop, tx_eop, busy;
   logic [7:0] tx_data, hi_q;
   logic [15:0] exp_q[$];
   logic [15:0] key, stat, seq, endm, w, e;
   logic [31:0] pres[64];
   logic [15:0] off[8];
   logic [47:0] t0, tacc;
   logic [31:0] cfg[5] = '{32'h0c, 32'h00, 32'h16, 32'h10, 32'h0a};
   int mismatches, samples_checked, widx, n, gg;
   int seed = 97;
   spf_framer spf_framer_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .tx_ready, .tx_data, .tx_valid, .tx_sop, .tx_eop, .busy);
   spf_sink spf_sink_inst (.pclk, .presetn, .stall, .tx_ready);
   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end
   task automatic check(input string nm, input logic [47:0] seen, input logic [47:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch %s exp %h seen %h", nm, exp, seen);
      end
   endtask : check
   task automatic conclude();
      $display("checked %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : conclude
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int k;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 16);
      rd_q = prdata;
      err_q = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
      if (k >= 16) begin
         mismatches++;
         conclude();
      end
   endtask : apb
   task automatic rchk(input logic [11:0] a, input logic [31:0] x, input logic er);
      apb(1'b0, a, 32'h0);
      check("rdata", rd_q, x);
      check("slverr", err_q, er);
   endtask : rchk
   function automatic logic [15:0] health(input logic [31:0] f, input logic [31:0] h);
      if (f[CTRL_LAYOUT_B]) return {14'h2000, f[CTRL_HEATER] ? h[17:16] : 2'h0};
      return {6'h00, h[9], h[8] & f[CTRL_HEATER], h[7:3], f[CTRL_PURGE] ? h[2:0] : 3'h0};
   endfunction : health
   always @(posedge pclk) begin
      if (presetn && tx_valid && tx_ready) begin
         check("sop", tx_sop, !hi_seen && widx == 0);
         check("eop", tx_eop, hi_seen && widx == (grp ? 26 : 146));
         if (!hi_seen) begin
            hi_q = tx_data;
         end else begin
            w = {hi_q, tx_data};
            e = exp_q.size() > 0 ? exp_q.pop_front() : 16'hxxxx;
            if (widx >= 2 && widx <= 4) tacc = {tacc[31:0], w};
            else if (widx == (grp ? 25 : 145)) check("health", w, e);
            else check("word", w, e);
            if (widx == 4) check("time", tacc - t0 < 48'h40, 1'b1);
            widx = tx_eop ? 0 : widx + 1;
         end
         hi_seen = !hi_seen;
      end
   end
   initial begin
      {presetn, psel, penable, pwrite, stall, hi_seen} = 6'h0;
      paddr = 12'h0;
      pwdata = 32'h0;
      {mismatches, samples_checked, widx} = 0;
      seq = 16'h0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rchk(REG_STATUS, 32'h0, 1'b0);
      rchk(REG_END, {16'h0, END_RST}, 1'b0);
      apb(1'b1, REG_SEQ, 32'h1234);
      rchk(REG_SEQ, 32'h0, 1'b0);
      rchk(12'h030, 32'h0, 1'b1);
      rchk(12'h002, 32'h0, 1'b1);
      for (int t = 0; t < 5; t++) begin
         c = cfg[t];
         grp = c[CTRL_GROUP_MODE];
         stall <= t[0];
         key = 16'($random(seed));
         stat = t == 0 ? STATUS_RST : 16'($random(seed));
         endm = t == 0 ? END_RST : 16'($random(seed));
         hreg = $random(seed);
         temp = $random(seed);
         apb(1'b1, REG_KEY, {16'h0, key});
         if (t > 0) apb(1'b1, REG_STATUS, {16'h0, stat});
         if (t > 0) apb(1'b1, REG_END, {16'h0, endm});
         apb(1'b1, REG_HEALTH, hreg);
         apb(1'b1, REG_TEMP, temp);
         for (int i = 0; i < 8; i++) begin
            off[i] = 16'($random(seed));
            apb(1'b1, 12'(12'h040 + 4 * i), {16'h0, off[i]});
         end
         for (int i = 0; i < 64; i++) begin
            pres[i] = $random(seed);
            apb(1'b1, 12'(12'h100 + 4 * i), pres[i]);
         end
         rchk(REG_KEY, {16'h0, key}, 1'b0);
         rchk(REG_HEALTH, {14'h0, hreg[17:0]}, 1'b0);
         rchk(REG_TEMP, temp, 1'b0);
         rchk(12'h05c, {16'h0, off[7]}, 1'b0);
         rchk(12'h1fc, pres[63], 1'b0);
         for (int g = 0; g < (grp ? 8 : 1); g++) begin
            exp_q.push_back(grp ? key + 16'(g) : key);
            exp_q.push_back(grp ? LEN_GROUP : LEN_FULL);
            repeat (3) exp_q.push_back(16'h0);
            exp_q.push_back(stat);
            exp_q.push_back(seq);
            seq++;
            for (int k = 0; k < (grp ? 1 : 8); k++) begin
               gg = grp ? g : k;
               if (!grp) exp_q.push_back(off[gg]);
               for (int j = 0; j < 8; j++) begin
                  exp_q.push_back(pres[gg + 8 * j][31:16]);
                  exp_q.push_back(pres[gg + 8 * j][15:0]);
               end
            end
            exp_q.push_back(temp[31:16]);
            exp_q.push_back(temp[15:0]);
            exp_q.push_back(health(c, hreg));
            exp_q.push_back(endm);
         end
         t0 = {16'($random(seed)), 32'($random(seed))};
         apb(1'b1, REG_TIME_LO, t0[31:0]);
         apb(1'b1, REG_TIME_HI, {16'h0, t0[47:32]});
         apb(1'b0, REG_TIME_LO, 32'h0);
         check("time_lo", rd_q - t0[31:0] < 32'h40, 1'b1);
         apb(1'b1, REG_CTRL, c | 32'h1);
         if (grp) apb(1'b1, REG_CTRL, c | 32'h1);
         n = 0;
         while ((exp_q.size() > 0 || busy !== 1'b0) && n < 20000) begin
            @(posedge pclk);
            n++;
         end
         if (n >= 20000) begin
            mismatches++;
            conclude();
         end
         rchk(REG_SEQ, {16'h0, seq}, 1'b0);
         rchk(REG_CTRL, {27'h0, c[4:1], 1'b0}, 1'b0);
         rchk(REG_STATE, 32'h70, 1'b0);
         $display("test %0d done", t);
      end
      conclude();
   end
endmodule : tb_top
